//--- hdl/mrb_defines.vh
// shared constants for the move / rotate / branch execution core
// assumes it is included by every design file that needs opcodes or flag bits
`ifndef MRB_DEFINES_VH
`define MRB_DEFINES_VH

// move group opcodes
`define MRB_OP_COPY_RR 8'h10
`define MRB_OP_COPY_TO_IND 8'h11
`define MRB_OP_COPY_FROM_IND 8'h12
`define MRB_OP_COPY_IMM 8'h13
`define MRB_OP_CODE_RD 8'h14
`define MRB_OP_CODE_WR 8'h15
`define MRB_OP_DATA_RD 8'h16
`define MRB_OP_DATA_WR 8'h17
`define MRB_OP_STACK_POP 8'h18
`define MRB_OP_STACK_PUSH 8'h19
`define MRB_OP_TECH_RD 8'h1A
`define MRB_OP_TECH_WR 8'h1B
`define MRB_OP_PAIR_COPY 8'h1C
// rotate group spans these two codes
`define MRB_OP_ROT_FIRST 8'h30
`define MRB_OP_ROT_LAST 8'h36
// branch group
`define MRB_OP_JUMP_PREFIX 5'h04
`define MRB_OP_CALL 8'h27
`define MRB_OP_SUB_EXIT 8'h28
`define MRB_OP_INT_EXIT 8'h29
`define MRB_OP_IND_JUMP 8'h2A

// flags register location and bit positions
`define MRB_FLAGS_ADDR 8'hFF
`define MRB_FLAG_Z 6
`define MRB_FLAG_S 5
`define MRB_FLAG_C 1

// further wait states for data-space copies with external rw memory
`define MRB_DATA_EXTRA_WAITS 8'h04
// longest instruction in bytes
`define MRB_MAX_BYTES 2'h3

`endif

//--- hdl/mrb_timing.v
// opcode table: length in bytes, base cycles, cycles per wait state
// assumes the opcode input is stable for the whole instruction after fetch
`timescale 1ns/1ns
`include "mrb_defines.vh"
module mrb_timing (
  input wire [7:0] opcode,
  output wire [1:0] len,
  output wire [3:0] base,
  output wire [2:0] perWait,
  output wire known,
  output wire dataSpace
);
  // packed as {known, len, base, perWait}
  function [9:0] lookup;
    input [7:0] op;
    begin
      case (op)
        8'h10, 8'h11, 8'h13: lookup = {1'h1, 2'h3, (op == 8'h13) ? 4'h4 : 4'h5, 3'h3};
        8'h12: lookup = {1'h1, 2'h3, 4'h6, 3'h3};
        8'h14, 8'h16: lookup = {1'h1, 2'h3, 4'h7, 3'h4};
        8'h15, 8'h17: lookup = {1'h1, 2'h3, 4'h8, 3'h4};
        8'h18: lookup = {1'h1, 2'h3, 4'hA, 3'h3};
        8'h19: lookup = {1'h1, 2'h3, 4'h9, 3'h3};
        8'h1A, 8'h1B, 8'h1C: lookup = {1'h1, 2'h3, 4'h7, 3'h3};
        8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36: lookup = {1'h1, 2'h2, 4'h5, 3'h2};
        8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27: lookup = {1'h1, 2'h3, 4'h3, 3'h3};
        8'h28, 8'h29: lookup = {1'h1, 2'h1, 4'h2, 3'h1};
        8'h2A: lookup = {1'h1, 2'h2, 4'h4, 3'h2};
        // outside this core: skipped as a one-byte no-op
        default: lookup = {1'h0, 2'h1, 4'h2, 3'h1};
      endcase
    end
  endfunction

  wire [9:0] entry;
  assign entry = lookup(opcode);
  assign known = entry[9];
  assign len = entry[8:7];
  assign base = entry[6:3];
  assign perWait = entry[2:0];
  assign dataSpace = (opcode == `MRB_OP_DATA_RD) || (opcode == `MRB_OP_DATA_WR);
endmodule // mrb_timing

//--- hdl/mrb_shifter.v
// byte rotate and shift unit, purely combinational
// assumes kind is the low three opcode bits of the rotate group
`timescale 1ns/1ns
module mrb_shifter (
  input wire [2:0] kind,
  input wire [7:0] din,
  input wire carryIn,
  output reg [7:0] dout,
  output reg carryOut
);
  // nine-bit forms feed the old carry into the vacated bit
  always @* begin
    dout = din;
    carryOut = carryIn;
    case (kind)
      3'h0: begin
        dout = {din[6:0], din[7]};
        carryOut = din[7];
      end
      3'h1: begin
        dout = {din[0], din[7:1]};
        carryOut = din[0];
      end
      3'h2: begin
        dout = {din[6:0], carryIn};
        carryOut = din[7];
      end
      3'h3: begin
        dout = {carryIn, din[7:1]};
        carryOut = din[0];
      end
      3'h4: begin
        dout = {din[6:0], 1'h0};
        carryOut = din[7];
      end
      3'h5: begin
        dout = {1'h0, din[7:1]};
        carryOut = din[0];
      end
      3'h6: begin
        dout = {din[7], din[7:1]};
        carryOut = din[0];
      end
      default: begin
        dout = din;
        carryOut = carryIn;
      end
    endcase
  end
endmodule // mrb_shifter

//--- hdl/mrb_core.v
// execution core for the move, rotate/shift and branch instruction groups
// assumes all memories answer a read in the cycle the registered address is shown
`timescale 1ns/1ns
`include "mrb_defines.vh"
module mrb_core #(
  parameter RS_DEPTH = 8,
  parameter RS_AW = 3
) (
  input wire clk,
  input wire rst,
  input wire [2:0] waitStates,
  input wire dataExtraWait,
  input wire extRwSel,
  output reg [15:0] codeAddr,
  output reg codeRe,
  output reg codeWe,
  output reg [7:0] codeWdata,
  input wire [7:0] codeRdata,
  output reg [7:0] regAddr,
  output reg regWe,
  output reg [7:0] regWdata,
  input wire [7:0] regRdata,
  output reg [15:0] dataAddr,
  output reg dataRe,
  output reg dataWe,
  output reg [7:0] dataWdata,
  input wire [7:0] dataRdata,
  output reg [15:0] techAddr,
  output reg techRe,
  output reg techWe,
  output reg [7:0] techWdata,
  input wire [7:0] techRdata,
  output reg [15:0] pc,
  output reg carry,
  output reg zero,
  output reg sign,
  output reg retired,
  output reg illegalOp
);
  localparam ST_FETCH = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg [1:0] state;
  reg [2:0] step;
  reg [1:0] idx;
  reg [7:0] cyc;
  reg [7:0] opcode;
  reg [7:0] b1;
  reg [7:0] b2;
  reg [7:0] tmp;
  reg [15:0] tgt;
  reg [15:0] npc;
  reg [RS_AW-1:0] rsp;
  reg rsPush;
  reg [18:0] rsData;
  reg [18:0] retStack [0:RS_DEPTH-1];

  wire [7:0] opIn;
  wire [1:0] len;
  wire [3:0] base;
  wire [2:0] perWait;
  wire known;
  wire dataSpace;
  wire [7:0] shOut;
  wire shCarry;
  wire [7:0] waitCount;
  wire [7:0] total;
  wire [7:0] flagsByte;
  wire [7:0] rdv;
  wire [15:0] seqPc;
  wire [7:0] ptrReg;
  wire [7:0] spaceData;
  wire [18:0] rsTop;

  // opcode is taken straight off the bus on the first fetch edge
  assign opIn = (state == ST_FETCH && idx == 2'h0) ? codeRdata : opcode;

  mrb_timing timing (
    .opcode(opIn),
    .len(len),
    .base(base),
    .perWait(perWait),
    .known(known),
    .dataSpace(dataSpace)
  );

  mrb_shifter shifter (
    .kind(opcode[2:0]),
    .din(rdv),
    .carryIn(carry),
    .dout(shOut),
    .carryOut(shCarry)
  );

  // cycle budget; the SRAM itself is never stretched, only the listed counts
  assign waitCount = {5'h00, waitStates} +
    ((dataSpace && dataExtraWait && extRwSel) ? `MRB_DATA_EXTRA_WAITS : 8'h00);
  assign total = {4'h0, base} + ({5'h00, perWait} * waitCount);

  // flags live here, so reads of the flags address see the live bits
  assign flagsByte = ({7'h00, zero} << `MRB_FLAG_Z) | ({7'h00, sign} << `MRB_FLAG_S) |
    ({7'h00, carry} << `MRB_FLAG_C);
  assign rdv = (regAddr == `MRB_FLAGS_ADDR) ? flagsByte : regRdata;
  assign seqPc = pc + {14'h0000, len};
  // stores name the pointer in the first operand, loads in the second
  assign ptrReg = opcode[0] ? b1 : b2;
  assign spaceData = (opcode == `MRB_OP_CODE_RD) ? codeRdata :
    (opcode == `MRB_OP_DATA_RD) ? dataRdata : techRdata;
  assign rsTop = retStack[rsp - {{(RS_AW-1){1'b0}}, 1'b1}];

  function taken;
    input [2:0] cond;
    input c;
    input z;
    input s;
    begin
      case (cond)
        3'h0: taken = c;
        3'h1: taken = ~c;
        3'h2: taken = z;
        3'h3: taken = ~z;
        3'h4: taken = s;
        3'h5: taken = ~s;
        default: taken = 1'b1;
      endcase
    end
  endfunction

  // register write; a write to the flags address also loads the flags
  task wrReg;
    input [7:0] a;
    input [7:0] d;
    begin
      regWe <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      if (a == `MRB_FLAGS_ADDR) begin
        zero <= d[`MRB_FLAG_Z];
        sign <= d[`MRB_FLAG_S];
        carry <= d[`MRB_FLAG_C];
      end
    end
  endtask

  // back to fetch at the new address
  task retireTo;
    input [15:0] np;
    begin
      pc <= np;
      codeAddr <= np;
      codeRe <= 1'b1;
      state <= ST_FETCH;
      idx <= 2'h0;
      step <= 3'h0;
      cyc <= 8'h00;
      retired <= 1'b1;
    end
  endtask

  // work done; hold until the cycle budget is spent
  task finish;
    input [15:0] np;
    begin
      npc <= np;
      state <= ST_WAIT;
      if (cyc >= total - 8'h01) retireTo(np);
    end
  endtask

  // one-byte memory accesses to code, data or technology space
  task spaceAccess;
    input wr;
    input [15:0] a;
    input [7:0] d;
    begin
      case (opcode[3:1])
        3'h2: begin
          codeAddr <= a;
          codeRe <= ~wr;
          codeWe <= wr;
          codeWdata <= d;
        end
        3'h3: begin
          dataAddr <= a;
          dataRe <= ~wr;
          dataWe <= wr;
          dataWdata <= d;
        end
        default: begin
          techAddr <= a;
          techRe <= ~wr;
          techWe <= wr;
          techWdata <= d;
        end
      endcase
    end
  endtask

  // return stack storage, written the cycle after a call's last byte is fetched
  always @(posedge clk) begin
    if (rsPush) begin
      retStack[rsp - {{(RS_AW-1){1'b0}}, 1'b1}] <= rsData;
    end
  end

  // fetch, execute and budget sequencer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_FETCH;
      step <= 3'h0;
      idx <= 2'h0;
      cyc <= 8'h00;
      opcode <= 8'h00;
      b1 <= 8'h00;
      b2 <= 8'h00;
      tmp <= 8'h00;
      tgt <= 16'h0000;
      npc <= 16'h0000;
      rsp <= {RS_AW{1'b0}};
      rsPush <= 1'b0;
      rsData <= 19'h00000;
      pc <= 16'h0000;
      codeAddr <= 16'h0000;
      codeRe <= 1'b1;
      codeWe <= 1'b0;
      codeWdata <= 8'h00;
      regAddr <= 8'h00;
      regWe <= 1'b0;
      regWdata <= 8'h00;
      dataAddr <= 16'h0000;
      dataRe <= 1'b0;
      dataWe <= 1'b0;
      dataWdata <= 8'h00;
      techAddr <= 16'h0000;
      techRe <= 1'b0;
      techWe <= 1'b0;
      techWdata <= 8'h00;
      carry <= 1'b0;
      zero <= 1'b0;
      sign <= 1'b0;
      retired <= 1'b0;
      illegalOp <= 1'b0;
    end else begin
      // strobes are single-cycle unless re-asserted below
      cyc <= cyc + 8'h01;
      regWe <= 1'b0;
      codeRe <= 1'b0;
      codeWe <= 1'b0;
      dataRe <= 1'b0;
      dataWe <= 1'b0;
      techRe <= 1'b0;
      techWe <= 1'b0;
      rsPush <= 1'b0;
      retired <= 1'b0;
      illegalOp <= 1'b0;
      case (state)
        ST_FETCH: begin
          case (idx)
            2'h0: opcode <= codeRdata;
            2'h1: b1 <= codeRdata;
            default: b2 <= codeRdata;
          endcase
          if (idx == 2'h0 && !known) illegalOp <= 1'b1;
          if (idx != len - 2'h1) begin
            idx <= idx + 2'h1;
            codeAddr <= codeAddr + 16'h0001;
            codeRe <= 1'b1;
          end else if (idx == 2'h2 && opIn[7:3] == `MRB_OP_JUMP_PREFIX) begin
            // absolute target, high byte is on the bus now
            if (opIn == `MRB_OP_CALL) begin
              rsPush <= 1'b1;
              rsData <= {carry, sign, zero, seqPc};
              rsp <= rsp + {{(RS_AW-1){1'b0}}, 1'b1};
            end
            if (taken(opIn[2:0], carry, zero, sign)) finish({codeRdata, b1});
            else finish(seqPc);
          end else begin
            state <= ST_EXEC;
            step <= 3'h0;
          end
        end
        ST_EXEC: begin
          step <= step + 3'h1;
          case (opcode)
            `MRB_OP_COPY_RR: begin
              if (step == 3'h0) regAddr <= b2;
              else begin
                wrReg(b1, rdv);
                finish(seqPc);
              end
            end
            `MRB_OP_COPY_IMM: begin
              wrReg(b1, b2);
              finish(seqPc);
            end
            `MRB_OP_COPY_TO_IND: begin
              // one-byte pointer, so any address is allowed
              case (step)
                3'h0: regAddr <= b1;
                3'h1: begin
                  tmp <= rdv;
                  regAddr <= b2;
                end
                default: begin
                  wrReg(tmp, rdv);
                  finish(seqPc);
                end
              endcase
            end
            `MRB_OP_COPY_FROM_IND: begin
              case (step)
                3'h0: regAddr <= b2;
                3'h1: regAddr <= rdv;
                default: begin
                  wrReg(b1, rdv);
                  finish(seqPc);
                end
              endcase
            end
            `MRB_OP_CODE_RD, `MRB_OP_CODE_WR, `MRB_OP_DATA_RD, `MRB_OP_DATA_WR,
            `MRB_OP_TECH_RD, `MRB_OP_TECH_WR: begin
              case (step)
                3'h0: regAddr <= {ptrReg[7:1], 1'b0};
                3'h1: begin
                  tgt[7:0] <= rdv;
                  regAddr <= {ptrReg[7:1], 1'b1};
                end
                3'h2: begin
                  tgt[15:8] <= rdv;
                  if (opcode[0]) regAddr <= b2;
                  else spaceAccess(1'b0, {rdv, tgt[7:0]}, 8'h00);
                end
                3'h3: begin
                  if (opcode[0]) spaceAccess(1'b1, tgt, rdv);
                  else wrReg(b1, spaceData);
                  // a code write must leave the code bus before refetch
                  if (opcode != `MRB_OP_CODE_WR) finish(seqPc);
                end
                default: finish(seqPc);
              endcase
            end
            `MRB_OP_STACK_POP: begin
              case (step)
                3'h0: regAddr <= b2;
                3'h1: begin
                  tmp <= rdv + 8'h01;
                  wrReg(b2, rdv + 8'h01);
                end
                3'h2: regAddr <= tmp;
                default: begin
                  wrReg(b1, rdv);
                  finish(seqPc);
                end
              endcase
            end
            `MRB_OP_STACK_PUSH: begin
              case (step)
                3'h0: regAddr <= b2;
                3'h1: begin
                  tmp <= rdv;
                  regAddr <= b1;
                end
                3'h2: begin
                  wrReg(rdv, tmp);
                  tgt[7:0] <= rdv;
                end
                default: begin
                  wrReg(b1, tgt[7:0] - 8'h01);
                  finish(seqPc);
                end
              endcase
            end
            `MRB_OP_PAIR_COPY: begin
              case (step)
                3'h0: regAddr <= {b2[7:1], 1'b0};
                3'h1: begin
                  tmp <= rdv;
                  regAddr <= {b2[7:1], 1'b1};
                end
                3'h2: begin
                  wrReg({b1[7:1], 1'b0}, tmp);
                  tgt[7:0] <= rdv;
                end
                default: begin
                  wrReg({b1[7:1], 1'b1}, tgt[7:0]);
                  finish(seqPc);
                end
              endcase
            end
            `MRB_OP_SUB_EXIT, `MRB_OP_INT_EXIT: begin
              rsp <= rsp - {{(RS_AW-1){1'b0}}, 1'b1};
              if (opcode == `MRB_OP_INT_EXIT) begin
                carry <= rsTop[18];
                sign <= rsTop[17];
                zero <= rsTop[16];
              end
              finish(rsTop[15:0]);
            end
            `MRB_OP_IND_JUMP: begin
              case (step)
                3'h0: regAddr <= {b1[7:1], 1'b0};
                3'h1: begin
                  tgt[7:0] <= rdv;
                  regAddr <= {b1[7:1], 1'b1};
                end
                default: finish({rdv, tgt[7:0]});
              endcase
            end
            default: begin
              if (opcode >= `MRB_OP_ROT_FIRST && opcode <= `MRB_OP_ROT_LAST) begin
                if (step == 3'h0) regAddr <= b1;
                else begin
                  wrReg(b1, shOut);
                  carry <= shCarry;
                  finish(seqPc);
                end
              end else begin
                finish(seqPc);
              end
            end
          endcase
        end
        ST_WAIT: begin
          if (cyc >= total - 8'h01) retireTo(npc);
        end
        default: state <= ST_FETCH;
      endcase
    end
  end
endmodule // mrb_core

//--- tb/mrb_mem.sv
// partner memories: code, register sram, data and technology spaces
// assumes the core shows registered addresses and strobes on clk
`timescale 1ns/1ns
module mrb_mem (
  input wire clk,
  input wire [15:0] codeAddr,
  input wire codeRe,
  input wire codeWe,
  input wire [7:0] codeWdata,
  output wire [7:0] codeRdata,
  input wire [7:0] regAddr,
  input wire regWe,
  input wire [7:0] regWdata,
  output wire [7:0] regRdata,
  input wire [15:0] dataAddr,
  input wire dataRe,
  input wire dataWe,
  input wire [7:0] dataWdata,
  output wire [7:0] dataRdata,
  input wire [15:0] techAddr,
  input wire techRe,
  input wire techWe,
  input wire [7:0] techWdata,
  output wire [7:0] techRdata
);
  reg [7:0] code [0:1023];
  reg [7:0] regs [0:255];
  reg [7:0] data [0:255];
  reg [7:0] tech [0:255];
  // unselected code, data and tech spaces show inverted bytes so a late sample never looks right; register reads are never inverted
  assign codeRdata = codeRe ? code[codeAddr[9:0]] : ~code[codeAddr[9:0]];
  assign regRdata = regs[regAddr];
  assign dataRdata = dataRe ? data[dataAddr[7:0]] : ~data[dataAddr[7:0]];
  assign techRdata = techRe ? tech[techAddr[7:0]] : ~tech[techAddr[7:0]];
  // writes land at the edge closing the strobe cycle
  always @(posedge clk) begin
    if (codeWe)
      code[codeAddr[9:0]] <= codeWdata;
    if (regWe)
      regs[regAddr] <= regWdata;
    if (dataWe)
      data[dataAddr[7:0]] <= dataWdata;
    if (techWe)
      tech[techAddr[7:0]] <= techWdata;
  end
endmodule // mrb_mem

//--- tb/mrb_core_checker.sv
// assertions on the core's ports: cycle counts, flags and branch targets
// assumes binding to mrb_core; the opcode is the first fetched byte
`timescale 1ns/1ns
module mrb_core_checker (
  input wire clk,
  input wire rst,
  input wire [2:0] waitStates,
  input wire dataExtraWait,
  input wire extRwSel,
  input wire [15:0] codeAddr,
  input wire codeRe,
  input wire [7:0] codeRdata,
  input wire carry,
  input wire zero,
  input wire sign,
  input wire retired
);
  reg first;
  reg [7:0] ph;
  reg [7:0] opc;
  reg [7:0] op1;
  reg [7:0] op2;
  reg [15:0] sp;
  wire [7:0] ws8 = {5'h00, waitStates};
  wire jTake = (opc[2:1] == 2'h0) ? carry : (opc[2:1] == 2'h1) ? zero : sign;
  // cycle index of the running instruction, saturating so it never wraps
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      first <= 1'b1;
      ph <= 8'h00;
      opc <= 8'h00;
      op1 <= 8'h00;
      op2 <= 8'h00;
      sp <= 16'h0000;
    end else begin
      first <= 1'b0;
      if (first || retired) begin
        ph <= 8'h01;
        opc <= codeRdata;
        sp <= codeAddr;
      end else if (ph != 8'hFF) begin
        ph <= ph + 8'h01;
      end
      if (ph == 8'h01 && !retired)
        op1 <= codeRdata;
      if (ph == 8'h02 && !retired)
        op2 <= codeRdata;
    end
  end
  default clocking ck @(posedge clk);
  endclocking
  default disable iff (rst);
  a_fetch_order: assert property ((opc[7:4] == 4'h1 || opc[7:3] == 5'h04) && !$past(rst)
    && (ph == 8'h01 || ph == 8'h02) |-> codeRe && codeAddr == $past(codeAddr) + 16'h0001)
    else $error("operand bytes not fetched in order");
  a_len_cap: assert property (retired && waitStates == 3'h0 && !(dataExtraWait && extRwSel)
    |-> ph <= 8'h0A) else $error("instruction longer than ten cycles");
  a_copy_time: assert property (retired && (opc == 8'h10 || opc == 8'h13)
    |-> ph == ((opc == 8'h10) ? 8'h05 : 8'h04) + 8'h03 * ws8)
    else $error("copy cycle count wrong");
  a_rot_time: assert property (retired && opc >= 8'h30 && opc <= 8'h36
    |-> ph == 8'h05 + 8'h02 * ws8) else $error("rotate cycle count wrong");
  a_jump_time: assert property (retired && opc >= 8'h20 && opc <= 8'h27
    |-> ph == 8'h03 + 8'h03 * ws8) else $error("branch cycle count wrong");
  a_data_wait: assert property (retired && opc == 8'h16
    |-> ph == 8'h07 + 8'h04 * (ws8 + ((dataExtraWait && extRwSel) ? 8'h04 : 8'h00)))
    else $error("data read cycle count wrong");
  a_rot_flags: assert property (opc >= 8'h30 && opc <= 8'h36 && op1 != 8'hFF
    && ph >= 8'h03 |-> $stable({sign, zero})) else $error("rotate moved sign or zero");
  a_copy_flags: assert property ((opc == 8'h10 || opc == 8'h13) && op1 != 8'hFF
    && ph >= 8'h03 |-> $stable({carry, sign, zero})) else $error("copy moved a flag");
  a_cond_jump: assert property (retired && opc >= 8'h20 && opc <= 8'h25
    |-> codeAddr == ((jTake ^ opc[0]) ? {op2, op1} : sp + 16'h0003))
    else $error("conditional branch went astray");
  a_jump_target: assert property (retired && (opc == 8'h26 || opc == 8'h27)
    |-> codeAddr == {op2, op1}) else $error("jump or call target wrong");
endmodule // mrb_core_checker
bind mrb_core mrb_core_checker i_mrb_core_checker (
  .clk(clk), .rst(rst), .waitStates(waitStates), .dataExtraWait(dataExtraWait),
  .extRwSel(extRwSel), .codeAddr(codeAddr), .codeRe(codeRe), .codeRdata(codeRdata),
  .carry(carry), .zero(zero), .sign(sign), .retired(retired)
);

//--- tb/mrb_core_tb.sv
// self-checking bench: small programs run from reset, results read back
// assumes mrb_mem answers every space combinationally
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  $display("Error %s expected %h seen %h", n, e, g); err_total++; end end
module mrb_core_tb;
  reg clk, rst, dataExtraWait, extRwSel;
  reg [2:0] waitStates;
  wire [15:0] codeAddr, dataAddr, techAddr, pc;
  wire [7:0] codeWdata, codeRdata, regAddr, regWdata, regRdata;
  wire [7:0] dataWdata, dataRdata, techWdata, techRdata;
  wire codeRe, codeWe, regWe, dataRe, dataWe, techRe, techWe;
  wire carry, zero, sign, retired, illegalOp;
  int err_total = 0, check_count = 0, cnt, lastRet, nRet, i, nIll;
  int lens [0:15];
  mrb_core i_mrb_core (.clk(clk), .rst(rst), .waitStates(waitStates),
    .dataExtraWait(dataExtraWait), .extRwSel(extRwSel), .codeAddr(codeAddr),
    .codeRe(codeRe), .codeWe(codeWe), .codeWdata(codeWdata), .codeRdata(codeRdata),
    .regAddr(regAddr), .regWe(regWe), .regWdata(regWdata), .regRdata(regRdata),
    .dataAddr(dataAddr), .dataRe(dataRe), .dataWe(dataWe), .dataWdata(dataWdata),
    .dataRdata(dataRdata), .techAddr(techAddr), .techRe(techRe), .techWe(techWe),
    .techWdata(techWdata), .techRdata(techRdata), .pc(pc), .carry(carry),
    .zero(zero), .sign(sign), .retired(retired), .illegalOp(illegalOp));
  mrb_mem i_mrb_mem (.clk(clk), .codeAddr(codeAddr), .codeRe(codeRe), .codeWe(codeWe),
    .codeWdata(codeWdata), .codeRdata(codeRdata), .regAddr(regAddr), .regWe(regWe),
    .regWdata(regWdata), .regRdata(regRdata), .dataAddr(dataAddr), .dataRe(dataRe),
    .dataWe(dataWe), .dataWdata(dataWdata), .dataRdata(dataRdata),
    .techAddr(techAddr), .techRe(techRe), .techWe(techWe), .techWdata(techWdata),
    .techRdata(techRdata));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // cycles between retire pulses give each instruction's length
  always @(posedge clk) begin
    if (rst) begin
      cnt <= 0;
      lastRet <= 0;
      nRet <= 0;
      nIll <= 0;
    end else begin
      cnt <= cnt + 1;
      // skipped opcodes are counted so the pulse is judged after it falls
      if (illegalOp === 1'b1) nIll <= nIll + 1;
      if (retired === 1'b1 && nRet < 16) begin
        lens[nRet] <= cnt - lastRet;
        lastRet <= cnt;
        nRet <= nRet + 1;
      end
    end
  end
  task give_verdict;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // reset the core and wipe every space so old programs cannot leak in
  task start(input [2:0] ws, input ex);
    @(posedge clk);
    rst <= 1'b1;
    waitStates <= ws;
    dataExtraWait <= ex;
    extRwSel <= ex;
    @(posedge clk);
    for (i = 0; i < 1024; i++)
      i_mrb_mem.code[i] = 8'h00;
    for (i = 0; i < 256; i++) begin
      i_mrb_mem.regs[i] = 8'h00;
      i_mrb_mem.data[i] = 8'h00;
      i_mrb_mem.tech[i] = 8'h00;
    end
  endtask
  task put(input [9:0] a, input [7:0] b0, input [7:0] b1, input [7:0] b2);
    i_mrb_mem.code[a] = b0;
    i_mrb_mem.code[a + 10'h001] = b1;
    i_mrb_mem.code[a + 10'h002] = b2;
  endtask
  // release reset if held, then wait for n retirements in all
  task run(input int n);
    int k;
    @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 400 && nRet < n; k++)
      @(posedge clk);
    if (nRet < n) begin
      $display("Error retire count expected %0d seen %0d", n, nRet);
      err_total++;
      give_verdict;
    end
  endtask
  task copy_test(input [2:0] ws);
    start(ws, 1'b0);
    i_mrb_mem.regs[8'h20] = 8'h5A;
    put(10'h000, 8'h10, 8'h21, 8'h20);
    put(10'h003, 8'h13, 8'h22, 8'hA5);
    put(10'h006, 8'h13, 8'hFF, 8'h62); // flags as destination
    run(2);
    `CHK("copy rr", 8'h5A, i_mrb_mem.regs[8'h21])
    `CHK("copy imm", 8'hA5, i_mrb_mem.regs[8'h22])
    `CHK("flags kept", 3'b000, {carry, sign, zero})
    `CHK("rr cycles", 32'h5 + 32'h3 * ws, lens[0])
    `CHK("imm cycles", 32'h4 + 32'h3 * ws, lens[1])
    run(3);
    `CHK("flags loaded", 3'b111, {carry, sign, zero})
    $display("copy test done");
  endtask
  task rot_test;
    logic [7:0] res [0:6] = '{8'h2F, 8'hCB, 8'h2E, 8'h4B, 8'h2E, 8'h4B, 8'hCB};
    int k;
    for (k = 0; k < 7; k++) begin
      start(3'h1, 1'b0);
      i_mrb_mem.regs[8'h40] = 8'h97;
      put(10'h000, 8'h13, 8'hFF, 8'h60); // zero and sign set, carry clear
      put(10'h003, 8'h30 | k[7:0], 8'h40, 8'h00);
      run(2);
      `CHK("rotate result", res[k], i_mrb_mem.regs[8'h40])
      `CHK("rotate flags", 3'b111, {carry, sign, zero})
      `CHK("rotate cycles", 32'h7, lens[1])
    end
    $display("rotate test done");
  endtask
  task branch_test;
    int j, k;
    reg take;
    for (j = 0; j < 3; j++) begin
      for (k = 0; k < 7; k++) begin
        start(3'h0, 1'b0);
        take = (k == 6) || ((k[2:1] == j[1:0]) ^ k[0]);
        put(10'h000, 8'h13, 8'hFF, (j == 0) ? 8'h02 : (j == 1) ? 8'h40 : 8'h20);
        put(10'h003, 8'h20 | k[7:0], 8'h40, 8'h01); // low byte first
        put(10'h006, 8'h13, 8'h30, 8'h22);
        put(10'h140, 8'h13, 8'h30, 8'h11);
        run(3);
        `CHK("branch path", take ? 8'h11 : 8'h22, i_mrb_mem.regs[8'h30])
        `CHK("branch cycles", 32'h3, lens[1])
      end
    end
    $display("branch test done");
  endtask
  task call_test;
    start(3'h1, 1'b0);
    i_mrb_mem.regs[8'h50] = 8'h40; // even pointer, low byte
    i_mrb_mem.regs[8'h51] = 8'h01;
    put(10'h000, 8'h27, 8'h20, 8'h00);
    put(10'h003, 8'h2A, 8'h50, 8'h00);
    put(10'h020, 8'h00, 8'h28, 8'h00); // unknown byte is skipped first
    put(10'h140, 8'h13, 8'h31, 8'h77);
    run(5);
    `CHK("indirect target", 8'h77, i_mrb_mem.regs[8'h31])
    `CHK("pc after jump", 16'h0143, pc)
    `CHK("skip count", 32'h1, nIll)
    `CHK("call cycles", 32'h6, lens[0])
    `CHK("skip cycles", 32'h3, lens[1])
    `CHK("return cycles", 32'h3, lens[2])
    `CHK("indirect cycles", 32'h6, lens[3])
    $display("call test done");
  endtask
  task data_test;
    start(3'h1, 1'b1);
    i_mrb_mem.regs[8'h60] = 8'h80; // even pointers
    i_mrb_mem.regs[8'h62] = 8'h10;
    i_mrb_mem.regs[8'h33] = 8'hC7;
    i_mrb_mem.regs[8'h72] = 8'h11;
    i_mrb_mem.regs[8'h73] = 8'h22;
    i_mrb_mem.data[8'h80] = 8'h3C;
    put(10'h000, 8'h16, 8'h32, 8'h60);
    put(10'h003, 8'h1B, 8'h62, 8'h33);
    put(10'h006, 8'h1C, 8'h70, 8'h72);
    put(10'h009, 8'h11, 8'h72, 8'h73); // pointer 72 holds 11, odd is fine
    put(10'h00C, 8'h12, 8'h45, 8'h72);
    put(10'h00F, 8'h1A, 8'h47, 8'h62);
    put(10'h012, 8'h18, 8'h46, 8'h62);
    put(10'h015, 8'h19, 8'h62, 8'h33);
    put(10'h018, 8'h17, 8'h60, 8'h46);
    run(9);
    `CHK("data read", 8'h3C, i_mrb_mem.regs[8'h32])
    `CHK("data cycles", 32'd27, lens[0])
    `CHK("tech write", 8'hC7, i_mrb_mem.tech[8'h10])
    `CHK("tech cycles", 32'hA, lens[1])
    `CHK("pair word", 16'h2211, {i_mrb_mem.regs[8'h71], i_mrb_mem.regs[8'h70]})
    `CHK("pair cycles", 32'hA, lens[2])
    `CHK("indirect copies", 8'h22, i_mrb_mem.regs[8'h45])
    `CHK("tech read", 8'hC7, i_mrb_mem.regs[8'h47])
    `CHK("stack pointer", 8'h10, i_mrb_mem.regs[8'h62])
    `CHK("push and pop", 16'hC722, {i_mrb_mem.regs[8'h11], i_mrb_mem.regs[8'h46]})
    `CHK("data write", 8'h22, i_mrb_mem.data[8'h80])
    $display("data test done");
  endtask
  initial begin
    rst = 1'b1;
    waitStates = 3'h0;
    dataExtraWait = 1'b0;
    extRwSel = 1'b0;
    repeat (8) @(posedge clk);
    copy_test(3'h0);
    copy_test(3'h2);
    rot_test;
    branch_test;
    call_test;
    data_test;
    give_verdict;
  end
endmodule // mrb_core_tb
